// *** sim/dmhu_link_monitor.sv ***
// Concurrent checks on the link between the host end and the device end.
`timescale 1ns/1ps
module dmhu_link_monitor #(
  parameter longint unsigned RESTORE_CYC = 100,
  parameter int unsigned     BOOT_CYC    = 64
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Link pins.
  input wire logic devTxd,
  input wire logic devCts,
  input wire logic fwReady,
  input wire logic modeState,
  input wire logic modeToggle,
  input wire logic defaultsRestore,
  // Device configuration and restore pulse.
  input wire logic cfgDualEnable,
  input wire logic restoreDefaults
);
  // Cycles with ready low, and restore held high since the last pulse.
  logic [15:0] lowCnt;
  logic [15:0] holdCnt;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Counters saturate so a long run never wraps into a false failure.
  always_ff @(posedge ref_clk)
  begin
    if (rst || fwReady)
      lowCnt <= 16'h0;
    else if (lowCnt != 16'hFFFF)
      lowCnt <= lowCnt + 16'h1;
    if (rst || restoreDefaults || !defaultsRestore)
      holdCnt <= 16'h0;
    else if (holdCnt != 16'hFFFF)
      holdCnt <= holdCnt + 16'h1;
  end

  a_ready_boot_low: assert property ($rose(fwReady) |-> lowCnt >= BOOT_CYC - 1)
    else $error("ready rose before boot time");
  a_cts_ready: assert property (devCts == fwReady)
    else $error("clear to send differs from ready");
  a_ready_fall: assert property ($fell(fwReady) |-> restoreDefaults)
    else $error("ready fell without a restore");
  a_state_boot: assert property (!fwReady |-> !modeState)
    else $error("mode state high while booting");
  a_txd_idle: assert property (!fwReady |-> devTxd)
    else $error("serial out not idle while booting");
  a_enter_command: assert property (cfgDualEnable && fwReady && modeState && $rose(modeToggle)
    |-> ##[1:2] !modeState) else $error("toggle edge did not enter command");
  a_leave_command: assert property (cfgDualEnable && fwReady && !modeState && $rose(modeToggle)
    |-> ##[1:2] modeState) else $error("toggle edge did not leave command");
  a_state_cause: assert property (fwReady && $fell(modeState) |-> modeToggle)
    else $error("mode state fell without toggle");
  a_no_dual: assert property (!cfgDualEnable && $past(fwReady) && fwReady |-> modeState)
    else $error("mode changed while dual disabled");
  a_start_ready: assert property ($fell(modeToggle) |-> fwReady)
    else $error("toggle lowered before ready");
  a_restore_hold: assert property (restoreDefaults |-> holdCnt >= RESTORE_CYC - 1)
    else $error("restore before full hold");
  a_restore_boot: assert property (restoreDefaults |=> !restoreDefaults ##[0:8] !fwReady)
    else $error("restore pulse not followed by reboot");

  // Main scenarios reached.
  c_enter: cover property (fwReady && $fell(modeState));
  c_leave: cover property (fwReady && $rose(modeState) && $past(fwReady));
  c_restore: cover property (restoreDefaults);
endmodule

// *** sim/dual_mode_host_uart_tb.sv ***
// Self-checking bench joining the host end and the device end.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((e) !== (g)) begin bad_count++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
`define WAITV(c) for (g = 0; g < 3000 && !(c); g++) @(posedge ref_clk); \
  if (!(c)) bad_count++;
module dual_mode_host_uart_tb;
  // Fastest rate gives sixteen cycles a bit; restore hold is shortened.
  localparam logic [4:0]      SEL   = 5'h11;
  localparam longint unsigned HOLD  = 100;
  localparam int              LIMIT = 30000;
  // Clock, reset and user-side signals of both ends.
  logic       ref_clk  = 1'b0;
  logic       rst      = 1'b1;
  logic       hTxValid = 1'b0;
  logic [7:0] hTxData  = 8'h00;
  logic       hTxReady;
  logic       hRxValid;
  logic [7:0] hRxData;
  logic       cmdReq   = 1'b0;
  logic       dataReq  = 1'b0;
  logic       restReq  = 1'b0;
  logic       inCmd;
  logic       hBusy;
  logic       dual     = 1'b1;
  logic       dTxValid = 1'b0;
  logic [7:0] dTxData  = 8'h00;
  logic       dTxReady;
  logic       payValid;
  logic [7:0] payData;
  logic       cmdValid;
  logic [7:0] cmdData;
  logic       restPulse;
  // Counters and the reference model: byte queues and expected state.
  int         bad_count       = 0;
  int         samples_checked = 0;
  int         cycles          = 0;
  int         g;
  int         t0;
  logic       expCmd = 1'b0;
  logic [8:0] ex;
  logic [7:0] qDev[$];
  logic [7:0] qHost[$];

  always #12.5 ref_clk = ~ref_clk;

  dmhu_link_if link();
  dmhu_host #(.BAUD_SEL(SEL), .DATA_BITS(4'h8), .RESTORE_CYC(HOLD)) dmhu_host_i (
    .ref_clk(ref_clk), .rst(rst), .link(link), .txValid(hTxValid), .txData(hTxData),
    .txReady(hTxReady), .rxValid(hRxValid), .rxData(hRxData), .cmdRequest(cmdReq),
    .dataRequest(dataReq), .restoreRequest(restReq), .inCommand(inCmd), .busy(hBusy));
  dmhu_device #(.RESTORE_CYC(HOLD), .BOOT_CYC(dmhu_pkg::BOOT_CYC)) dmhu_device_i (
    .ref_clk(ref_clk), .rst(rst), .link(link), .cfgDualEnable(dual), .cfgBaudSel(SEL),
    .cfgDataBits(4'h8), .txValid(dTxValid), .txData(dTxData), .txReady(dTxReady),
    .payloadValid(payValid), .payloadData(payData), .commandValid(cmdValid),
    .commandData(cmdData), .restoreDefaults(restPulse));
  dmhu_link_monitor #(.RESTORE_CYC(HOLD), .BOOT_CYC(dmhu_pkg::BOOT_CYC)) dmhu_link_monitor_i (
    .ref_clk(ref_clk), .rst(rst), .devTxd(link.devTxd), .devCts(link.devCts),
    .fwReady(link.fwReady), .modeState(link.modeState), .modeToggle(link.modeToggle),
    .defaultsRestore(link.defaultsRestore), .cfgDualEnable(dual), .restoreDefaults(restPulse));

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Offers one byte at a rising edge and holds it until the rising edge after the falling edge where ready is seen.
  task automatic send(input bit toDev, input logic [7:0] b);
    int k;
    @(posedge ref_clk);
    if (toDev)
    begin
      qDev.push_back(b);
      hTxValid <= 1'b1;
      hTxData  <= b;
    end
    else
    begin
      qHost.push_back(b);
      dTxValid <= 1'b1;
      dTxData  <= b;
    end
    for (k = 0; k < 2000; k++)
    begin
      @(negedge ref_clk);
      if ((toDev ? hTxReady : dTxReady) === 1'b1)
        break;
    end
    // A byte never taken counts as a mismatch.
    if (k == 2000)
      bad_count++;
    @(posedge ref_clk);
    if (toDev)
      hTxValid <= 1'b0;
    else
      dTxValid <= 1'b0;
  endtask

  // Samples one device frame at bit centres; a bit lasts sixteen cycles here.
  task automatic frame(input logic [7:0] b);
    int i;
    @(negedge link.devTxd);
    repeat (8) @(posedge ref_clk);
    `CHK("start bit", 1'b0, link.devTxd)
    for (i = 0; i < 8; i++)
    begin
      repeat (16) @(posedge ref_clk);
      `CHK("data bit", b[i], link.devTxd)
    end
    repeat (16) @(posedge ref_clk);
    `CHK("stop bit", 1'b1, link.devTxd)
  endtask

  // Every received byte must match the model queue; device end bytes must also match the expected state.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (payValid === 1'b1)
    begin
      ex = (qDev.size() > 0) ? {expCmd, qDev.pop_front()} : 9'h1FF;
      `CHK("payload", ex, {1'b0, payData})
    end
    if (cmdValid === 1'b1)
    begin
      ex = (qDev.size() > 0) ? {~expCmd, qDev.pop_front()} : 9'h1FF;
      `CHK("command", ex, {1'b0, cmdData})
    end
    if (hRxValid === 1'b1)
    begin
      ex = (qHost.size() > 0) ? {1'b0, qHost.pop_front()} : 9'h1FF;
      `CHK("host receive", ex, {1'b0, hRxData})
    end
    if (cycles == LIMIT)
    begin
      bad_count++;
      results();
    end
  end

  // Boot, full duplex traffic, command round trip, restore, then dual disabled.
  initial
  begin
    logic [7:0] r;
    r = 8'($urandom(32'h65878CBB));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    `CHK("boot ready", 1'b0, link.fwReady)
    `WAITV(link.fwReady === 1'b1)
    `CHK("boot length", 1'b1, cycles >= 5 + dmhu_pkg::BOOT_CYC)
    `WAITV(link.modeState === 1'b1)
    `CHK("start toggle", 1'b0, link.modeToggle)
    `CHK("transparent", 1'b1, link.modeState)
    fork
      frame(r);
      begin
        send(1'b0, r);
        repeat (3) send(1'b0, 8'($urandom));
      end
      repeat (4) send(1'b1, 8'($urandom));
    join
    `WAITV(qDev.size() == 0 && qHost.size() == 0)
    expCmd <= 1'b1;
    cmdReq <= 1'b1;
    `WAITV(inCmd === 1'b1)
    cmdReq <= 1'b0;
    `WAITV(hBusy === 1'b0)
    `CHK("command state", 1'b0, link.modeState)
    `CHK("toggle reset", 1'b0, link.modeToggle)
    repeat (2) send(1'b1, 8'($urandom));
    send(1'b0, 8'($urandom));
    `WAITV(qDev.size() == 0 && qHost.size() == 0)
    dataReq <= 1'b1;
    `WAITV(inCmd === 1'b0)
    dataReq <= 1'b0;
    expCmd  <= 1'b0;
    `WAITV(hBusy === 1'b0)
    `CHK("back to transparent", 1'b1, link.modeState)
    send(1'b1, 8'($urandom));
    `WAITV(qDev.size() == 0)
    dual    <= 1'b0;
    restReq <= 1'b1;
    t0 = cycles;
    `WAITV(restPulse === 1'b1)
    restReq <= 1'b0;
    `CHK("restore pulse", 1'b1, restPulse)
    `CHK("restore hold", 1'b1, cycles - t0 >= HOLD)
    `WAITV(link.fwReady === 1'b0)
    `CHK("reboot", 1'b0, link.fwReady)
    `WAITV(link.fwReady === 1'b1)
    repeat (2) @(posedge ref_clk);
    cmdReq <= 1'b1;
    repeat (200) @(posedge ref_clk);
    `CHK("dual disabled", 1'b1, link.modeState)
    results();
  end
endmodule

// *** verilog/dmhu_device.sv ***
// Device end: payload serial port with transparent and command states.
// Functional notes
// R1: Baud taken only from the enumerated set.
// R2: Five to eight data bits, LSB first.
// R3: Dual switching only when configuration enables it.
// R4: Ready held low in boot, then high.
// R5: Host drives toggle high to low to start.
// R6: Mode state high while transparent.
// R7: Toggle rising edge requests command state.
// R8: State falls low; host then lowers toggle.
// R9: Host repeats toggle to return transparent.
// R10: Restore defaults after ten second hold.
// R11: Transparent bytes never parsed as commands.
`timescale 1ns/1ps
module dmhu_device #(
  parameter longint unsigned RESTORE_CYC = dmhu_pkg::RESTORE_HOLD_CYC,
  parameter int unsigned     BOOT_CYC    = dmhu_pkg::BOOT_CYC
) (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Link to the host.
  dmhu_link_if.device     link,
  // Stored configuration.
  input  wire logic       cfgDualEnable,
  input  wire logic [4:0] cfgBaudSel,
  input  wire logic [3:0] cfgDataBits,
  // Payload transmit side.
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady,
  // Payload receive side, transparent state only.
  output logic            payloadValid,
  output logic [7:0]      payloadData,
  // Command receive side, command state and the wait for the start toggle, while mode state is low.
  output logic            commandValid,
  output logic [7:0]      commandData,
  // Defaults restore pulse.
  output logic            restoreDefaults
);
  typedef struct packed {
    logic [dmhu_pkg::DIV_W-1:0] div;
    logic [dmhu_pkg::DIV_W-1:0] divLoad;
    logic [3:0]  bits;
    logic [3:0]  txTick;
    logic [3:0]  txBit;
    logic [9:0]  txShift;
    logic        txBusy;
    logic        txd;
    logic [3:0]  rxTick;
    logic [3:0]  rxBit;
    logic [7:0]  rxShift;
    logic        rxBusy;
    logic        payValid;
    logic        cmdValid;
    logic [7:0]  rxData;
    dmhu_pkg::dmhu_mode_e mode;
    logic [31:0] bootCnt;
    logic        ready;
    logic        stateOut;
    logic        toggleLast;
    logic        dual;
    logic [39:0] holdCnt;
    logic        restore;
  } dmhu_dev_s;

  dmhu_dev_s st;
  dmhu_dev_s next_st;
  logic tick;
  logic toggleRise;

  // Next state of the whole device end.
  always_comb
  begin
    next_st = st;
    next_st.payValid = 1'b0;
    next_st.cmdValid = 1'b0;
    next_st.restore = 1'b0;
    tick = (st.div == '0);
    next_st.div = tick ? st.divLoad - 1'b1 : st.div - 1'b1;
    toggleRise = link.modeToggle && !st.toggleLast;
    next_st.toggleLast = link.modeToggle;
    // Boot: configuration is latched only while booting, so a mid-frame change cannot corrupt a character.
    unique case (st.mode)
      dmhu_pkg::DMHU_BOOT:
      begin
        next_st.bootCnt = st.bootCnt + 32'h1;
        next_st.divLoad = dmhu_pkg::baud_div(cfgBaudSel);  // [R1]
        next_st.bits = (cfgDataBits < dmhu_pkg::DATA_BITS_MIN ||
                        cfgDataBits > dmhu_pkg::DATA_BITS_MAX) ?
                       dmhu_pkg::DATA_BITS_DEFAULT : cfgDataBits;  // [R2]
        next_st.dual = cfgDualEnable;  // [R3]
        // Divider held at zero in boot, so the first tick after boot comes at once.
        // Reloading it from the reset value would stall the port for a full counter wrap.
        next_st.div = '0;  // [R1]
        if (st.bootCnt >= BOOT_CYC - 1)
        begin
          next_st.ready = 1'b1;  // [R4]
          next_st.mode = cfgDualEnable ? dmhu_pkg::DMHU_WAIT_START :
                                         dmhu_pkg::DMHU_TRANSPARENT;
          next_st.stateOut = !cfgDualEnable;
        end
      end
      dmhu_pkg::DMHU_WAIT_START:
        // Start condition: toggle seen low after ready rises.
        if (!link.modeToggle)
        begin
          next_st.mode = dmhu_pkg::DMHU_TRANSPARENT;
          next_st.stateOut = 1'b1;  // [R6]
        end
      dmhu_pkg::DMHU_TRANSPARENT:
      begin
        next_st.stateOut = 1'b1;  // [R6]
        if (st.dual && toggleRise)  // [R3] [R7]
        begin
          next_st.mode = dmhu_pkg::DMHU_COMMAND;
          next_st.stateOut = 1'b0;  // [R8]
        end
      end
      dmhu_pkg::DMHU_COMMAND:
        if (toggleRise)  // [R9]
        begin
          next_st.mode = dmhu_pkg::DMHU_TRANSPARENT;
          next_st.stateOut = 1'b1;
        end
    endcase
    // Transmitter, LSB first, held off while the host withdraws its request.
    if (!st.txBusy)
    begin
      if (txValid && link.hostRts && st.ready)
      begin
        // Bits above the character width are forced high, so the stop bit follows at once.
        next_st.txShift = {1'b1, txData | ~(8'hFF >> (4'h8 - st.bits)), 1'b0};  // [R2]
        next_st.txBusy = 1'b1;
        next_st.txBit = 4'h0;
        next_st.txTick = 4'h0;
      end
    end
    else if (tick)
    begin
      next_st.txTick = st.txTick + 4'h1;
      if (st.txTick == 4'hF)
      begin
        next_st.txShift = {1'b1, st.txShift[9:1]};
        next_st.txBit = st.txBit + 4'h1;
        if (st.txBit == st.bits + 4'h1)  // [R2]
          next_st.txBusy = 1'b0;
      end
    end
    next_st.txd = st.txBusy ? st.txShift[0] : 1'b1;
    // Receiver: bytes routed by mode state, never both ways.
    if (tick && st.ready)
    begin
      if (!st.rxBusy)
      begin
        if (!link.hostTxd)
        begin
          next_st.rxBusy = 1'b1;
          next_st.rxTick = 4'h0;
          next_st.rxBit = 4'h0;
        end
      end
      else
      begin
        next_st.rxTick = st.rxTick + 4'h1;
        if (st.rxTick == 4'h7)
        begin
          if (st.rxBit == 4'h0 && link.hostTxd)
            next_st.rxBusy = 1'b0;
          else if (st.rxBit == st.bits + 4'h1)
          begin
            next_st.rxBusy = 1'b0;
            next_st.rxData = st.rxShift >> (4'h8 - st.bits);  // [R2]
            next_st.payValid = link.hostTxd && st.stateOut;  // [R11]
            next_st.cmdValid = link.hostTxd && !st.stateOut;  // [R11]
          end
          else if (st.rxBit != 4'h0)
            next_st.rxShift = {link.hostTxd, st.rxShift[7:1]};
          next_st.rxBit = st.rxBit + 4'h1;
        end
      end
    end
    // Defaults restore: one pulse once the input has been high the full hold time.
    if (link.defaultsRestore)
    begin
      if (st.holdCnt != 40'(RESTORE_CYC))
        next_st.holdCnt = st.holdCnt + 40'h1;
      if (st.holdCnt == 40'(RESTORE_CYC) - 40'h1)
        next_st.restore = 1'b1;  // [R10]
    end
    else
      next_st.holdCnt = '0;
    // A restore reboots the port so the default configuration is taken up.
    if (next_st.restore)
    begin
      next_st.mode = dmhu_pkg::DMHU_BOOT;
      next_st.bootCnt = '0;
      next_st.ready = 1'b0;  // [R4]
      next_st.stateOut = 1'b0;
      // A character in flight is cut, so the line idles high while ready is low.
      next_st.txBusy = 1'b0;
      next_st.txd = 1'b1;
      next_st.rxBusy = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st <= '0;
      st.txd <= 1'b1;
      st.toggleLast <= 1'b1;
      st.bits <= dmhu_pkg::DATA_BITS_DEFAULT;
      st.mode <= dmhu_pkg::DMHU_BOOT;
    end
    else
      st <= next_st;
  end

  assign link.devTxd = st.txd;
  assign link.devCts = st.ready;
  assign link.fwReady = st.ready;
  assign link.modeState = st.stateOut;
  assign txReady = !st.txBusy && link.hostRts && st.ready;
  assign payloadValid = st.payValid;
  assign payloadData = st.rxData;
  assign commandValid = st.cmdValid;
  assign commandData = st.rxData;
  assign restoreDefaults = st.restore;
endmodule

// *** verilog/dmhu_host.sv ***
// Host end: serial port plus mode toggle and defaults restore sequencing.
`timescale 1ns/1ps
module dmhu_host #(
  parameter logic [4:0] BAUD_SEL = dmhu_pkg::BAUD_SEL_DEFAULT,
  parameter logic [3:0] DATA_BITS = dmhu_pkg::DATA_BITS_DEFAULT,
  parameter longint unsigned RESTORE_CYC = dmhu_pkg::RESTORE_HOLD_CYC
) (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Link to the device.
  dmhu_link_if.host       link,
  // User transmit side.
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady,
  // User receive side.
  output logic            rxValid,
  output logic [7:0]      rxData,
  // Mode requests and status.
  input  wire logic       cmdRequest,
  input  wire logic       dataRequest,
  input  wire logic       restoreRequest,
  output logic            inCommand,
  output logic            busy
);
  localparam logic [dmhu_pkg::DIV_W-1:0] DIV = dmhu_pkg::baud_div(BAUD_SEL);

  typedef enum logic [2:0] {H_WAIT_READY, H_START, H_IDLE, H_RAISE, H_LOWER, H_RESTORE}
    dmhu_hseq_e;

  typedef struct packed {
    logic [dmhu_pkg::DIV_W-1:0] div;
    logic [3:0]  txTick;
    logic [3:0]  txBit;
    logic [9:0]  txShift;
    logic        txBusy;
    logic        txd;
    logic [3:0]  rxTick;
    logic [3:0]  rxBit;
    logic [7:0]  rxShift;
    logic        rxBusy;
    logic        rxValid;
    logic [7:0]  rxData;
    dmhu_hseq_e  seq;
    logic        targetCmd;
    logic [39:0] holdCnt;
    logic        toggle;
    logic        restore;
    logic        inCommand;
    logic        busy;
  } dmhu_host_s;

  dmhu_host_s st;
  dmhu_host_s next_st;
  logic tick;

  // Next state: shared oversample divider, framer, sampler and toggle sequencer.
  always_comb
  begin
    next_st = st;
    next_st.rxValid = 1'b0;
    tick = (st.div == '0);
    next_st.div = tick ? DIV - 1'b1 : st.div - 1'b1;
    // Transmitter, LSB first, paced by the device clear to send. [R2]
    if (!st.txBusy)
    begin
      if (txValid && link.devCts)
      begin
        // Bits above the character width are forced high, so the stop bit follows at once.
        next_st.txShift = {1'b1, txData | ~(8'hFF >> (4'h8 - DATA_BITS)), 1'b0};  // [R2]
        next_st.txBusy = 1'b1;
        next_st.txBit = 4'h0;
        next_st.txTick = 4'h0;
      end
    end
    else if (tick)
    begin
      next_st.txTick = st.txTick + 4'h1;
      if (st.txTick == 4'hF)
      begin
        next_st.txShift = {1'b1, st.txShift[9:1]};
        next_st.txBit = st.txBit + 4'h1;
        if (st.txBit == DATA_BITS + 4'h1)
          next_st.txBusy = 1'b0;
      end
    end
    next_st.txd = st.txBusy ? st.txShift[0] : 1'b1;
    // Receiver samples mid bit. [R1] [R2]
    if (tick)
    begin
      if (!st.rxBusy)
      begin
        if (!link.devTxd)
        begin
          next_st.rxBusy = 1'b1;
          next_st.rxTick = 4'h0;
          next_st.rxBit = 4'h0;
        end
      end
      else
      begin
        next_st.rxTick = st.rxTick + 4'h1;
        if (st.rxTick == 4'h7)
        begin
          if (st.rxBit == 4'h0 && link.devTxd)
            next_st.rxBusy = 1'b0;
          else if (st.rxBit == DATA_BITS + 4'h1)
          begin
            next_st.rxBusy = 1'b0;
            next_st.rxValid = link.devTxd;
            next_st.rxData = st.rxShift >> (4'h8 - DATA_BITS);
          end
          else if (st.rxBit != 4'h0)
            next_st.rxShift = {link.devTxd, st.rxShift[7:1]};
          next_st.rxBit = st.rxBit + 4'h1;
        end
      end
    end
    // Toggle sequencer.
    unique case (st.seq)
      H_WAIT_READY:
        if (link.fwReady)
          next_st.seq = H_START;
      H_START:
      begin
        next_st.toggle = 1'b0;  // [R5]
        if (link.modeState)
          next_st.seq = H_IDLE;
      end
      H_IDLE:
        if (restoreRequest)
        begin
          next_st.seq = H_RESTORE;
          next_st.holdCnt = '0;
          next_st.restore = 1'b1;
        end
        else if (cmdRequest && link.modeState)
        begin
          next_st.seq = H_RAISE;
          next_st.targetCmd = 1'b1;
          next_st.toggle = 1'b1;  // [R7]
        end
        else if (dataRequest && !link.modeState)
        begin
          next_st.seq = H_RAISE;
          next_st.targetCmd = 1'b0;
          next_st.toggle = 1'b1;  // [R9]
        end
      H_RAISE:
        // Toggle is only returned low once the state output has moved. [R8]
        if (link.modeState != st.targetCmd)
        begin
          next_st.toggle = 1'b0;
          next_st.seq = H_LOWER;
        end
      H_LOWER:
        next_st.seq = H_IDLE;
      H_RESTORE:
      begin
        next_st.holdCnt = st.holdCnt + 40'h1;
        if (st.holdCnt >= 40'(RESTORE_CYC))  // [R10]
        begin
          next_st.restore = 1'b0;
          next_st.seq = H_WAIT_READY;
        end
      end
    endcase
    next_st.inCommand = !link.modeState && st.seq != H_WAIT_READY;
    next_st.busy = st.seq != H_IDLE;
  end

  // State register.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st <= '0;
      st.txd <= 1'b1;
      st.toggle <= 1'b1;
      st.seq <= H_WAIT_READY;
      st.busy <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign link.hostTxd = st.txd;
  assign link.hostRts = 1'b1;
  assign link.modeToggle = st.toggle;
  assign link.defaultsRestore = st.restore;
  assign txReady = !st.txBusy && link.devCts;
  assign rxValid = st.rxValid;
  assign rxData = st.rxData;
  assign inCommand = st.inCommand;
  assign busy = st.busy;
endmodule

// *** verilog/dmhu_link_if.sv ***
// Pin bundle between the device end and the host end.
`timescale 1ns/1ps
interface dmhu_link_if;
  // Serial data, device to host and host to device.
  logic devTxd;
  logic hostTxd;
  // Flow control: device clear to send, host request to send.
  logic devCts;
  logic hostRts;
  // Ready, mode state, mode toggle and defaults restore.
  logic fwReady;
  logic modeState;
  logic modeToggle;
  logic defaultsRestore;

  // Documented device end.
  modport device (
    output devTxd, devCts, fwReady, modeState,
    input  hostTxd, hostRts, modeToggle, defaultsRestore
  );
  // Host microcontroller end.
  modport host (
    input  devTxd, devCts, fwReady, modeState,
    output hostTxd, hostRts, modeToggle, defaultsRestore
  );
endinterface

// *** verilog/dmhu_pkg.sv ***
// Shared constants and types for the dual mode host serial port.
package dmhu_pkg;
  // System clock rate in hertz.
  localparam int unsigned CLK_HZ = 40000000;
  // Oversampling factor of the serial line.
  localparam int unsigned OVERSAMPLE = 16;
  // Default baud rate.
  localparam int unsigned BAUD_DEFAULT = 115200;
  // Default character width in bits.
  localparam logic [3:0] DATA_BITS_DEFAULT = 4'h8;
  // Least and greatest character width.
  localparam logic [3:0] DATA_BITS_MIN = 4'h5;
  localparam logic [3:0] DATA_BITS_MAX = 4'h8;
  // Number of selectable baud rates.
  localparam int unsigned BAUD_COUNT = 18;
  // Index of the default rate in the baud table.
  localparam logic [4:0] BAUD_SEL_DEFAULT = 5'h0C;
  // Hold time of the defaults restore input in seconds.
  localparam int unsigned RESTORE_HOLD_S = 10;
  // Hold time of the defaults restore input in clock cycles.
  localparam longint unsigned RESTORE_HOLD_CYC = longint'(RESTORE_HOLD_S) * CLK_HZ;
  // Boot time in clock cycles before the ready output rises.
  localparam int unsigned BOOT_CYC = 64;
  // Enumerated baud set.
  localparam int unsigned BAUD_TABLE [BAUD_COUNT] = '{
    300, 600, 1200, 2400, 4800, 9600, 14400, 19200, 28800,
    38400, 56000, 57600, 115200, 128000, 256000, 520000, 780000, 1500000};
  // Width of the oversample tick divider.
  localparam int unsigned DIV_W = 16;

  // Oversample tick divide value for a baud index, at least one cycle.
  function automatic logic [DIV_W-1:0] baud_div(input logic [4:0] sel);
    int unsigned d;
    d = CLK_HZ / (BAUD_TABLE[(sel < 5'(BAUD_COUNT)) ? sel : BAUD_SEL_DEFAULT] * OVERSAMPLE);
    if (d < 1)
      d = 1;
    return DIV_W'(d);
  endfunction

  // Port mode of the device end.
  typedef enum logic [1:0] {
    DMHU_BOOT,
    DMHU_WAIT_START,
    DMHU_TRANSPARENT,
    DMHU_COMMAND
  } dmhu_mode_e;
endpackage
